// >>> hdl/gst_defines.svh
// constants of the gated sixteen-bit timer/counter
// How it works
// - 16-bit up-counter; writing either byte replaces it at once.
// - source bit 0 counts instruction clock, 1 counts external input.
// - external mode counts rising input edges, synchronised or not.
// - sync-bypass bit set makes external counting asynchronous.
// - counter mode needs a falling edge before first counted rise.
// - prescaler divides by 1, 2, 4 or 8.
// - prescaler hidden from software, cleared by any count-byte write.
// - oscillator-enable starts low-power oscillator, only in allowed modes.
// - oscillator enabled forces port lines 5,4 direction 1, data 0.
// - asynchronous external counting continues in sleep and can wake.
// - switching sync mode may drop or add one increment.
// - byte reads are always valid; carry between reads is software's.
// - gate from gate pin or comparator, applied when gate-enable set.
// - gate-invert flips gate polarity for either source.
// - rollover FFFFh to 0000h sets the overflow flag.
// - interrupt needs flag, on, enable, peripheral and global enables.
// - overflow in sleep wakes; with global enable it vectors too.
// - count is capture/compare time base: captured, compared for match.
// - special trigger clears count without setting overflow flag.
// - count write beats a coincident special trigger.
// - on and gated runs only with gate active; off stops.
// - prescale field 11=/8, 10=/4, 01=/2, 00=/1.
// - gate-invert 1 means active high, 0 means active low.
// - internal source ignores the sync-bypass bit.
`ifndef GST_DEFINES_SVH
`define GST_DEFINES_SVH
`define GST_OFF_CONTROL   8'h00
`define GST_OFF_COUNT_LO  8'h04
`define GST_OFF_COUNT_HI  8'h08
`define GST_OFF_FLAGS     8'h0C
`define GST_OFF_COMPARE   8'h10
`define GST_OFF_CAPTURE   8'h14
`define GST_OFF_PORT      8'h18
`define GST_CTL_ON        0
`define GST_CTL_SRC       1
`define GST_CTL_BYPASS    2
`define GST_CTL_OSC       3
`define GST_CTL_PS_LO     4
`define GST_CTL_PS_HI     5
`define GST_CTL_GATE_EN   6
`define GST_CTL_GATE_INV  7
`define GST_CTL_GATE_SRC  8
`define GST_CTL_OVF_IE    9
`define GST_CTL_PERI_IE   10
`define GST_CTL_GLOB_IE   11
`define GST_CTL_W         12
`define GST_CONTROL_RST   12'h000
`define GST_PORT_DIR_RST  2'h3
`define GST_PORT_FORCED   2'h3
`define GST_PORT_ZERO     2'h0
`define GST_COUNT_MAX     16'hFFFF
`define GST_COUNT_ZERO    16'h0000
`define GST_PS_ZERO       3'h0
`define GST_DIV1_LAST     3'h0
`define GST_DIV2_LAST     3'h1
`define GST_DIV4_LAST     3'h3
`define GST_DIV8_LAST     3'h7
`define GST_INSTR_LAST    2'h3
`define GST_RESP_OKAY     2'h0
`define GST_RESP_SLVERR   2'h2
`define GST_SYNC_W        4
`endif

// >>> hdl/gst_pkg.sv
// types of the gated sixteen-bit timer/counter
package gst_pkg;
   typedef logic [15:0] gst_count_t;
   typedef enum logic [1:0] {
      GST_PS_DIV1 = 2'h0,
      GST_PS_DIV2 = 2'h1,
      GST_PS_DIV4 = 2'h2,
      GST_PS_DIV8 = 2'h3
   } gst_ps_t;
   typedef enum logic [2:0] {
      GST_REG_NONE, GST_REG_CONTROL, GST_REG_COUNT_LO, GST_REG_COUNT_HI,
      GST_REG_FLAGS, GST_REG_COMPARE, GST_REG_CAPTURE, GST_REG_PORT
   } gst_reg_t;
endpackage

// >>> hdl/gst_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`include "gst_defines.svh"
module gst_sync (
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   input  wire logic [`GST_SYNC_W-1:0] pinIn,
   output logic      [`GST_SYNC_W-1:0] syncOut
);
   logic [`GST_SYNC_W-1:0] stage1;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1  <= '0;
         syncOut <= '0;
      end else begin
         stage1  <= pinIn;
         syncOut <= stage1;
      end
   end
endmodule // gst_sync

// >>> hdl/gst_timer.sv
// gated sixteen-bit timer/counter with AXI4-Lite registers
`timescale 1ns/1ps
`include "gst_defines.svh"
module gst_timer (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [31:0]       awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [31:0]       araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              extCountPin,
   input  wire logic              gatePin,
   input  wire logic              secondCompOut,
   input  wire logic              sleepMode,
   input  wire logic              oscModeOk,
   input  wire logic [1:0]        portDataPin,
   input  wire logic              captureEvent,
   input  wire logic              specialTrigger,
   output gst_pkg::gst_count_t    countValue,
   output logic                   compareMatch,
   output logic                   overflowIrq,
   output logic                   wakeRequest,
   output logic                   vectorRequest,
   output logic                   oscRun,
   output logic [1:0]             portDirEff,
   output logic [1:0]             portDataView
);
   import gst_pkg::*;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic gst_reg_t decodeReg(input logic [31:0] addr);
      unique case (addr[7:0])
         `GST_OFF_CONTROL:  decodeReg = GST_REG_CONTROL;
         `GST_OFF_COUNT_LO: decodeReg = GST_REG_COUNT_LO;
         `GST_OFF_COUNT_HI: decodeReg = GST_REG_COUNT_HI;
         `GST_OFF_FLAGS:    decodeReg = GST_REG_FLAGS;
         `GST_OFF_COMPARE:  decodeReg = GST_REG_COMPARE;
         `GST_OFF_CAPTURE:  decodeReg = GST_REG_CAPTURE;
         `GST_OFF_PORT:     decodeReg = GST_REG_PORT;
         default:           decodeReg = GST_REG_NONE;
      endcase
      if (addr[31:8] != 24'h000000) begin
         decodeReg = GST_REG_NONE;
      end
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      mergeStrb = old;
   endfunction

   function automatic logic [2:0] divLast(input gst_ps_t sel);
      unique case (sel)
         GST_PS_DIV1: divLast = `GST_DIV1_LAST;
         GST_PS_DIV2: divLast = `GST_DIV2_LAST;
         GST_PS_DIV4: divLast = `GST_DIV4_LAST;
         GST_PS_DIV8: divLast = `GST_DIV8_LAST;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [`GST_CTL_W-1:0] control;
   logic [15:0]           compareVal;
   logic [15:0]           captureVal;
   logic [1:0]            portDirLatch;
   logic                  overflowFlag;
   logic [2:0]            prescCnt;
   logic [1:0]            instrPhase;
   logic                  extPrev;
   logic                  armed;
   logic                  awHeld;
   logic                  wHeld;
   logic [31:0]           awAddrQ;
   logic [31:0]           wDataQ;
   logic [3:0]            wStrbQ;
   logic [`GST_SYNC_W-1:0] pinSync;

   gst_sync u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pinIn   ({portDataPin, gatePin, extCountPin}),
      .syncOut (pinSync)
   );

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   wire     timerOn   = control[`GST_CTL_ON];
   wire     clockSrc  = control[`GST_CTL_SRC];
   wire     bypass    = control[`GST_CTL_BYPASS];
   wire     oscEn     = control[`GST_CTL_OSC];
   wire     gateEn    = control[`GST_CTL_GATE_EN];
   wire     gateInv   = control[`GST_CTL_GATE_INV];
   wire     gateSrc   = control[`GST_CTL_GATE_SRC];
   wire     ovfIe     = control[`GST_CTL_OVF_IE];
   wire     periIe    = control[`GST_CTL_PERI_IE];
   wire     globIe    = control[`GST_CTL_GLOB_IE];
   wire gst_ps_t psSel = gst_ps_t'(control[`GST_CTL_PS_HI:`GST_CTL_PS_LO]);
   wire     extSync   = pinSync[0];
   wire     gateSync  = pinSync[1];
   wire [1:0] portSync = pinSync[3:2];

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   wire        awTake  = awvalid & awready;
   wire        wTake   = wvalid & wready;
   wire        haveAw  = awHeld | awTake;
   wire        haveW   = wHeld | wTake;
   wire        doWrite = haveAw & haveW & ~bvalid;
   wire [31:0] addrW   = awTake ? awaddr : awAddrQ;
   wire [31:0] dataW   = wTake ? wdata : wDataQ;
   wire [3:0]  strbW   = wTake ? wstrb : wStrbQ;
   wire gst_reg_t wrSel = decodeReg(addrW);
   wire        nextAwHeld = haveAw & ~doWrite;
   wire        nextWHeld  = haveW & ~doWrite;
   wire        nextBvalid = doWrite | (bvalid & ~bready);
   wire        wrCtl  = doWrite & (wrSel == GST_REG_CONTROL);
   wire        wrLo   = doWrite & (wrSel == GST_REG_COUNT_LO) & strbW[0];
   wire        wrHi   = doWrite & (wrSel == GST_REG_COUNT_HI) & strbW[0];
   wire        wrFlag = doWrite & (wrSel == GST_REG_FLAGS) & strbW[0];
   wire        wrCmp  = doWrite & (wrSel == GST_REG_COMPARE);
   wire        wrPort = doWrite & (wrSel == GST_REG_PORT);
   wire        cntWr  = wrLo | wrHi;
   wire [31:0] ctlMerged  = mergeStrb({20'h00000, control}, dataW, strbW);
   wire [31:0] cmpMerged  = mergeStrb({16'h0000, compareVal}, dataW, strbW);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         awAddrQ <= '0;
         wDataQ  <= '0;
         wStrbQ  <= '0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `GST_RESP_OKAY;
      end else begin
         awHeld  <= nextAwHeld;
         wHeld   <= nextWHeld;
         awAddrQ <= awTake ? awaddr : awAddrQ;
         wDataQ  <= wTake ? wdata : wDataQ;
         wStrbQ  <= wTake ? wstrb : wStrbQ;
         awready <= ~nextAwHeld & ~nextBvalid;
         wready  <= ~nextWHeld & ~nextBvalid;
         bvalid  <= nextBvalid;
         if (doWrite) begin
            bresp <= (wrSel == GST_REG_NONE) ? `GST_RESP_SLVERR
                                             : `GST_RESP_OKAY;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   wire        arTake     = arvalid & arready;
   wire        nextRvalid = arTake | (rvalid & ~rready);
   wire gst_reg_t rdSel   = decodeReg(araddr);
   logic [31:0] rdMux;
   // byte reads come from the live count, not coherent across two reads
   assign rdMux =
      (rdSel == GST_REG_CONTROL)  ? {20'h00000, control} :
      (rdSel == GST_REG_COUNT_LO) ? {24'h000000, countValue[7:0]} :
      (rdSel == GST_REG_COUNT_HI) ? {24'h000000, countValue[15:8]} :
      (rdSel == GST_REG_FLAGS)    ? {29'h00000000, armed, oscRun,
                                     overflowFlag} :
      (rdSel == GST_REG_COMPARE)  ? {16'h0000, compareVal} :
      (rdSel == GST_REG_CAPTURE)  ? {16'h0000, captureVal} :
      (rdSel == GST_REG_PORT)     ? {28'h0000000, portDataView,
                                     portDirEff} :
      32'h00000000;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= `GST_RESP_OKAY;
      end else begin
         arready <= ~nextRvalid;
         rvalid  <= nextRvalid;
         if (arTake) begin
            rdata <= rdMux;
            rresp <= (rdSel == GST_REG_NONE) ? `GST_RESP_SLVERR
                                             : `GST_RESP_OKAY;
         end
      end
   end

   // ----------------------------------------------------------------
   // count clock, gate and prescaler
   // ----------------------------------------------------------------
   wire instrTick = (instrPhase == `GST_INSTR_LAST);
   wire extRise   = extSync & ~extPrev;
   wire extFall   = ~extSync & extPrev;
   // external rise counts only once a fall has been seen
   wire srcTick   = clockSrc ? (extRise & armed) : instrTick;
   wire gateRaw   = gateSrc ? secondCompOut : gateSync;
   wire gateLevel = gateInv ? gateRaw : ~gateRaw;
   wire runOk     = timerOn & (~gateEn | gateLevel);
   // sleep freezes all but asynchronous external counting
   wire asyncExt  = clockSrc & bypass;
   wire frozen    = sleepMode & ~asyncExt;
   wire preTick   = runOk & ~frozen & srcTick;
   wire incTick   = preTick & (prescCnt == divLast(psSel));
   wire ovfSet    = incTick & ~cntWr & ~specialTrigger &
                    (countValue == `GST_COUNT_MAX);
   wire ovfClr    = wrFlag & dataW[0];

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         instrPhase <= '0;
         extPrev    <= 1'b0;
         armed      <= 1'b0;
         prescCnt   <= `GST_PS_ZERO;
      end else begin
         instrPhase <= instrPhase + 2'h1;
         // mode switches reuse the edge history: one step gained/lost
         extPrev    <= extSync;
         if (!timerOn || cntWr) begin
            armed <= 1'b0;
         end else if (extFall) begin
            armed <= 1'b1;
         end
         if (cntWr) begin
            prescCnt <= `GST_PS_ZERO;
         end else if (incTick) begin
            prescCnt <= `GST_PS_ZERO;
         end else if (preTick) begin
            prescCnt <= prescCnt + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // counter, flag and registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         countValue   <= `GST_COUNT_ZERO;
         overflowFlag <= 1'b0;
         control      <= `GST_CONTROL_RST;
         compareVal   <= `GST_COUNT_ZERO;
         captureVal   <= `GST_COUNT_ZERO;
         portDirLatch <= `GST_PORT_DIR_RST;
      end else begin
         if (wrLo) begin
            countValue[7:0] <= dataW[7:0];
         end else if (wrHi) begin
            countValue[15:8] <= dataW[7:0];
         end else if (specialTrigger) begin
            countValue <= `GST_COUNT_ZERO;
         end else if (incTick) begin
            countValue <= countValue + 16'h0001;
         end
         // a rollover in the clearing cycle still lands
         if (ovfSet) begin
            overflowFlag <= 1'b1;
         end else if (ovfClr) begin
            overflowFlag <= 1'b0;
         end
         if (wrCtl) begin
            control <= ctlMerged[`GST_CTL_W-1:0];
         end
         if (wrCmp) begin
            compareVal <= cmpMerged[15:0];
         end
         if (captureEvent) begin
            captureVal <= countValue;
         end
         if (wrPort && strbW[0]) begin
            portDirLatch <= dataW[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   wire irqBase = overflowFlag & ovfIe & periIe & timerOn;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         compareMatch  <= 1'b0;
         overflowIrq   <= 1'b0;
         wakeRequest   <= 1'b0;
         vectorRequest <= 1'b0;
         oscRun        <= 1'b0;
         portDirEff    <= `GST_PORT_DIR_RST;
         portDataView  <= `GST_PORT_ZERO;
      end else begin
         compareMatch  <= (countValue == compareVal);
         overflowIrq   <= irqBase & globIe;
         wakeRequest   <= irqBase & sleepMode;
         vectorRequest <= irqBase & sleepMode & globIe;
         oscRun        <= oscEn & oscModeOk;
         portDirEff    <= oscEn ? `GST_PORT_FORCED : portDirLatch;
         portDataView  <= oscEn ? `GST_PORT_ZERO : portSync;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_low_byte_write: assert property (
      wrLo |=> countValue[7:0] == $past(dataW[7:0]))
      else $error("low byte write not applied");
   a_write_beats_trig: assert property (
      wrHi && specialTrigger |=> countValue[15:8] == $past(dataW[7:0]))
      else $error("trigger beat a count write");
   a_presc_cleared: assert property (
      cntWr |=> prescCnt == `GST_PS_ZERO)
      else $error("prescaler not cleared by count write");
   a_rearm_after_write: assert property (
      cntWr && clockSrc |=> !srcTick)
      else $error("counted rise without a prior fall");
   a_div8_step: assert property (
      preTick && !cntWr && psSel == GST_PS_DIV8 &&
      prescCnt != `GST_DIV8_LAST |=> prescCnt == $past(prescCnt) + 3'h1)
      else $error("divide by 8 prescaler skipped a step");
   a_overflow_sets: assert property (
      ovfSet |=> overflowFlag && countValue == `GST_COUNT_ZERO)
      else $error("rollover did not set flag");
   a_trig_no_flag: assert property (
      specialTrigger && !cntWr && !overflowFlag
      |=> countValue == `GST_COUNT_ZERO && !overflowFlag)
      else $error("special trigger misbehaved");
   a_off_holds: assert property (
      !timerOn && !cntWr && !specialTrigger |=> $stable(countValue))
      else $error("count moved while off");
   a_gate_blocks: assert property (
      timerOn && gateEn && !gateLevel |-> !incTick)
      else $error("count stepped with gate inactive");
   a_sleep_freeze: assert property (
      sleepMode && !(clockSrc && bypass) |-> !incTick)
      else $error("synchronous count stepped in sleep");
   a_irq_cause: assert property (
      overflowIrq |-> $past(overflowFlag && ovfIe && periIe &&
                            globIe && timerOn))
      else $error("interrupt without all enables");
   a_osc_port_force: assert property (
      oscEn ##1 oscEn |-> portDirEff == `GST_PORT_FORCED &&
                          portDataView == `GST_PORT_ZERO)
      else $error("port lines not forced");
endmodule // gst_timer

// >>> sim/gst_ext_src.sv
// external count clock source model for the timer bench
`timescale 1ns/1ps
module gst_ext_src (
   input  wire logic ref_clk,
   output logic      pinOut
);
   // idles low between bursts, like a gated clock source
   initial pinOut = 1'b0;
   task automatic burst(input int n);
      repeat (n) begin
         repeat (6) @(posedge ref_clk);
         pinOut <= 1'b1;
         repeat (6) @(posedge ref_clk);
         pinOut <= 1'b0;
      end
   endtask
endmodule // gst_ext_src

// >>> sim/gst_timer_tb.sv
// self-checking bench of the gated timer/counter
`timescale 1ns/1ps
`include "gst_defines.svh"
`define CHK(a,e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
 $display("ERROR %0t: got %h want %h", $time, (a), (e)); end end
module gst_timer_tb;
   import gst_pkg::*;
   logic ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, gatePin = 0, secondCompOut = 0;
   logic sleepMode = 0, oscModeOk = 0, captureEvent = 0;
   logic specialTrigger = 0, extCountPin;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, v;
   logic [3:0]  wstrb = 0;
   logic [1:0]  portDataPin = 0, bresp, rresp, r, portDirEff, portDataView;
   logic        awready, wready, bvalid, arready, rvalid, compareMatch;
   logic [1:0]  bq;
   logic        overflowIrq, wakeRequest, vectorRequest, oscRun;
   gst_count_t  countValue;
   int          error_cnt = 0, checked = 0, i, e;
   logic [11:0] gCfg [4] = '{12'h041, 12'h0C1, 12'h1C1, 12'h141};
   bit          gRun [4] = '{0, 1, 0, 1};
   always #4 ref_clk = ~ref_clk;
   gst_ext_src src_u (.ref_clk, .pinOut(extCountPin));
   gst_timer dut_u (.ref_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .extCountPin, .gatePin,
      .secondCompOut, .sleepMode, .oscModeOk, .portDataPin, .captureEvent,
      .specialTrigger, .countValue, .compareMatch, .overflowIrq,
      .wakeRequest, .vectorRequest, .oscRun, .portDirEff, .portDataView);
   // -----------------------------------------------------------------
   // bus tasks
   // -----------------------------------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1;
      w = 1;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1;
      wvalid <= 1;
      while (aw || w) begin
         @(posedge ref_clk);
         if (aw && awready === 1'b1) begin
            aw = 0;
            awvalid <= 0;
         end
         if (w && wready === 1'b1) begin
            w = 0;
            wvalid <= 0;
         end
      end
      bready <= 1;
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      bq = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] rs);
      araddr <= a;
      arvalid <= 1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 0;
      rready <= 1;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      wt(20000);
      error_cnt++;
      report_and_stop;
   end
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      wt(8);
      rst_n <= 1;
      wt(1);
      rd(`GST_OFF_CONTROL, v, r);
      `CHK(v, 32'h0)
      rd(32'h40, v, r);
      `CHK(r, `GST_RESP_SLVERR)
      wr(32'h40, 32'h1);
      `CHK(bq, `GST_RESP_SLVERR)
      wr(`GST_OFF_COUNT_LO, 32'hFE);
      wr(`GST_OFF_COUNT_HI, 32'hFF);
      `CHK(countValue, 16'hFFFE)
      `CHK(bq, `GST_RESP_OKAY)
      wr(`GST_OFF_CONTROL, 32'hE01);
      wt(40);
      rd(`GST_OFF_FLAGS, v, r);
      `CHK(v[0], 1'b1)
      `CHK(overflowIrq, 1'b1)
      wr(`GST_OFF_FLAGS, 32'h1);
      wt(2);
      `CHK(overflowIrq, 1'b0)
      wr(`GST_OFF_CONTROL, 32'h0);
      $display("test overflow done");
      specialTrigger <= 1;
      fork
         wr(`GST_OFF_COUNT_HI, 32'h12);
         begin
            wt(1);
            specialTrigger <= 0;
         end
      join
      `CHK(countValue[15:8], 8'h12)
      wr(`GST_OFF_COUNT_HI, 32'h0);
      wr(`GST_OFF_COUNT_LO, 32'h34);
      captureEvent <= 1;
      wt(1);
      captureEvent <= 0;
      rd(`GST_OFF_CAPTURE, v, r);
      `CHK(v[15:0], 16'h0034)
      wr(`GST_OFF_COMPARE, 32'h34);
      wt(2);
      `CHK(compareMatch, 1'b1)
      specialTrigger <= 1;
      wt(1);
      specialTrigger <= 0;
      wt(2);
      `CHK(countValue, 16'h0)
      `CHK(compareMatch, 1'b0)
      rd(`GST_OFF_FLAGS, v, r);
      `CHK(v[0], 1'b0)
      $display("test capture done");
      for (i = 0; i < 4; i++) begin
         wr(`GST_OFF_COUNT_LO, 32'h0);
         wr(`GST_OFF_CONTROL, {26'h0, i[1:0], 4'h1});
         wt(256);
         wr(`GST_OFF_CONTROL, {26'h0, i[1:0], 4'h0});
         e = 64 >> i;
         `CHK(countValue >= e - 1 && countValue <= e + 1, 1'b1)
      end
      $display("test prescale done");
      gatePin <= 1;
      for (i = 0; i < 4; i++) begin
         wr(`GST_OFF_COUNT_LO, 32'h0);
         wr(`GST_OFF_CONTROL, {20'h0, gCfg[i]});
         wt(64);
         wr(`GST_OFF_CONTROL, 32'h0);
         v[0] = gRun[i] ? (countValue > 14 && countValue < 19)
                        : countValue == 0;
         `CHK(v[0], 1'b1)
      end
      $display("test gate done");
      wr(`GST_OFF_COUNT_LO, 32'h0);
      wr(`GST_OFF_CONTROL, 32'h3);
      src_u.burst(5);
      wt(8);
      `CHK(countValue, 16'h4)
      wr(`GST_OFF_CONTROL, 32'h0);
      sleepMode <= 1;
      wr(`GST_OFF_COUNT_LO, 32'h0);
      wr(`GST_OFF_CONTROL, 32'h7);
      src_u.burst(5);
      wt(8);
      `CHK(countValue, 16'h4)
      wr(`GST_OFF_CONTROL, 32'h0);
      wr(`GST_OFF_COUNT_LO, 32'h0);
      wr(`GST_OFF_CONTROL, 32'h3);
      src_u.burst(5);
      wt(8);
      `CHK(countValue, 16'h0)
      wr(`GST_OFF_CONTROL, 32'h0);
      wr(`GST_OFF_COUNT_LO, 32'hFF);
      wr(`GST_OFF_COUNT_HI, 32'hFF);
      wr(`GST_OFF_CONTROL, 32'h607);
      src_u.burst(3);
      wt(8);
      `CHK({wakeRequest, vectorRequest}, 2'h2)
      wr(`GST_OFF_CONTROL, 32'hE07);
      wt(2);
      `CHK({wakeRequest, vectorRequest, overflowIrq}, 3'h7)
      wr(`GST_OFF_CONTROL, 32'h0);
      sleepMode <= 0;
      $display("test external done");
      oscModeOk <= 1;
      portDataPin <= 2'h3;
      wr(`GST_OFF_PORT, 32'h0);
      wt(4);
      `CHK({portDirEff, portDataView}, 4'h3)
      wr(`GST_OFF_CONTROL, 32'h8);
      wt(2);
      `CHK({oscRun, portDirEff, portDataView}, 5'h1C)
      oscModeOk <= 0;
      wt(2);
      `CHK(oscRun, 1'b0)
      $display("test oscillator done");
      report_and_stop;
   end
endmodule // gst_timer_tb
